/* design/fetch_seq_pkg.sv */
// constants, phase type and register map of the command fetch sequencer
// assumes a 32-bit Avalon-MM host and big-endian word bit numbering (bit 0 = msb)
// Operation
// (R1) output cycle: setup slot two clears top three holding bits; code gates this on the output-type bit (out_type_q)
// (R2) slot four of setup and order-send clears adder input register
// (R3) fetch timer starts at once when no memory access made yet
// (R4) fetch slot zero clears subtract, carry-in set gives plus one
// (R5) fetch slot zero loads command address plus one into adder register
// (R6) fetch slot zero clears memory address bits S15-S31
// (R7) fetch slot zero loads command address into S15-S30, S31 zero
// (R8) order-send timer waits for memory reply of first word
// (R9) order-send slot zero clears order register then copies I0-I7
// (R10) order-send slot zero sets address bit S31 for second word
// (R11) order-send slot zero sets error halt on first-word parity error
// (R12) jump is bit4 set, bits5-7 clear; slot zero loads M16-M31
// (R13) jump on second pass flags control error and error halt
// (R14) order-send slot four sets second-pass flag
// (R15) order-send slot zero clears buffer select zero when not jump
// (R16) slot two arms strobe acknowledge when not jump or error
// (R17) order-send slot four sets carry-in when jump
// (R18) slot four: started access without address accept sets timeout, halt
// (R19) jump without error returns to fetch with jump target
// (R20) not jump or error advances to second-word phase
// (R21) second-word timer waits for memory reply
// (R22) jump repeats fetch and order-send in same service cycle
// (R23) each phase has five slots; phase changes at slot four
// (R24) reset clears all phase latches, no timer running
package fetch_seq_pkg;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_SETUP  = 3'h1,
    PH_FETCH  = 3'h3,
    PH_ORDER  = 3'h2,
    PH_SECOND = 3'h6
  } phase_t;

  localparam int SLOT_COUNT = 5;

  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_CADDR  = 6'h08;
  localparam logic [5:0] OFS_ORDER  = 6'h0c;
  localparam logic [5:0] OFS_HOLD   = 6'h10;
  localparam logic [5:0] OFS_WORD2  = 6'h14;
  localparam logic [5:0] OFS_MADDR  = 6'h18;

  // control bits
  localparam int CTRL_START  = 0;
  localparam int CTRL_ORDOUT = 1;
  localparam int CTRL_OUTTYP = 2;

  // status bits
  localparam int ST_PHASE    = 0;
  localparam int ST_BUSY     = 3;
  localparam int ST_HALT     = 4;
  localparam int ST_TIMEOUT  = 5;
  localparam int ST_CTRLERR  = 6;
  localparam int ST_PARERR   = 7;
  localparam int ST_PASS2    = 8;
  localparam int ST_BSEL0    = 9;
  localparam int ST_DONE     = 10;
  localparam int ST_CARRY    = 11;

  // command word fields
  localparam int ORDER_MSB   = 31;
  localparam int JUMP_BIT    = 27;

  localparam logic [15:0] CADDR_RST = 16'h0000;
  localparam logic [7:0]  HOLD_RST  = 8'h00;
  localparam logic        BSEL0_RST = 1'b1;

endpackage : fetch_seq_pkg

/* design/slot_timer.sv */
// five-slot phase timer, a shift chain standing in for the delay line
// assumes go is only raised while busy is low
`timescale 1ns/1ps
`default_nettype none
module slot_timer #(
  parameter int SLOTS = fetch_seq_pkg::SLOT_COUNT
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             go,
  output logic      [SLOTS-1:0] slot,
  output logic                  busy
);

  logic [SLOTS-1:0] chain_q;

  // one slot per clock, t0 on the edge after go
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      chain_q <= '0;                                            // R24
    else
      chain_q <= {chain_q[SLOTS-2:0], go & ~busy};              // R23
  end

  assign slot = chain_q;
  assign busy = |chain_q;

endmodule : slot_timer
`default_nettype wire

/* design/channel_command_fetch_seq.sv */
// command fetch sequencer: setup end, fetch, order-send, second-word phases
// assumes a single-word-latency memory handshake and an Avalon-MM host
//
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module channel_command_fetch_seq (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // core memory
  output logic             mem_req,
  output logic      [16:0] mem_addr,
  input  wire logic        mem_addr_ack,
  input  wire logic        mem_reply,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_parity_err,
  // device controller
  output logic      [7:0]  order_lines,
  output logic             strobe_ack,
  input  wire logic        req_strobe,
  output logic             buffer_sel_zero
);

  fetch_seq_pkg::phase_t phase_q;

  logic [4:0]  slot;
  logic        timer_busy;
  logic        wait_q;
  logic        timer_go;
  logic [15:0] command_address_register_q;
  logic [15:0] adder_q;
  logic        adder_carry_in_q;
  logic        subtract_q;
  logic [16:0] maddr_q;
  logic [7:0]  hold_q;
  logic [7:0]  order_q;
  logic [31:0] word1_q;
  logic [31:0] word2_q;
  logic        error_halt_flag_q;
  logic        memory_timeout_flag_q;
  logic        ctrl_err_q;
  logic        parity_err_q;
  logic        second_pass_flag_q;
  logic        strobe_ack_arm_q;
  logic        strobe_ack_stage_two_q;
  logic        buffer_sel_zero_q;
  logic        memory_cycle_started_q;
  logic        memory_reply_seen_q;
  logic        address_accepted_q;
  logic        req_q;
  logic        done_q;
  logic        command_output_cycle_q;
  logic        out_type_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        start;
  logic        jump_command_detect;
  logic        t0;
  logic        t1;
  logic        t2;
  logic        t3;
  logic        t4;
  logic        in_fetch;
  logic        in_order;
  logic        go_on;

  slot_timer #(
    .SLOTS (fetch_seq_pkg::SLOT_COUNT)
  ) u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .go    (timer_go),
    .slot  (slot),
    .busy  (timer_busy)
  );

  assign t0 = slot[0];
  assign t1 = slot[1];
  assign t2 = slot[2];
  assign t3 = slot[3];
  assign t4 = slot[4];
  assign in_fetch = (phase_q == fetch_seq_pkg::PH_FETCH);
  assign in_order = (phase_q == fetch_seq_pkg::PH_ORDER);

  // bit 4 set, bits 5..7 clear of the order field
  assign jump_command_detect = word1_q[fetch_seq_pkg::JUMP_BIT]                 // R12
                             & ~|word1_q[fetch_seq_pkg::JUMP_BIT-1 -: 3];
  assign go_on = error_halt_flag_q | ~jump_command_detect;

  // bus slave: one wait state, then the answer
  assign start = avs_write & ack_q & (avs_address == fetch_seq_pkg::OFS_CTRL)
               & avs_writedata[fetch_seq_pkg::CTRL_START]
               & (phase_q == fetch_seq_pkg::PH_IDLE);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (avs_read & ~ack_q)
    begin
      rdata_q <= '0;
      unique case (avs_address)
        fetch_seq_pkg::OFS_CTRL:
        begin
          rdata_q[fetch_seq_pkg::CTRL_ORDOUT] <= command_output_cycle_q;
          rdata_q[fetch_seq_pkg::CTRL_OUTTYP] <= out_type_q;
        end
        fetch_seq_pkg::OFS_STATUS:
        begin
          rdata_q[fetch_seq_pkg::ST_PHASE +: 3] <= phase_q;
          rdata_q[fetch_seq_pkg::ST_BUSY]    <= phase_q != fetch_seq_pkg::PH_IDLE;
          rdata_q[fetch_seq_pkg::ST_HALT]    <= error_halt_flag_q;
          rdata_q[fetch_seq_pkg::ST_TIMEOUT] <= memory_timeout_flag_q;
          rdata_q[fetch_seq_pkg::ST_CTRLERR] <= ctrl_err_q;
          rdata_q[fetch_seq_pkg::ST_PARERR]  <= parity_err_q;
          rdata_q[fetch_seq_pkg::ST_PASS2]   <= second_pass_flag_q;
          rdata_q[fetch_seq_pkg::ST_BSEL0]   <= buffer_sel_zero_q;
          rdata_q[fetch_seq_pkg::ST_DONE]    <= done_q;
          rdata_q[fetch_seq_pkg::ST_CARRY]   <= adder_carry_in_q;
        end
        fetch_seq_pkg::OFS_CADDR: rdata_q[15:0] <= command_address_register_q;
        fetch_seq_pkg::OFS_ORDER: rdata_q[7:0]  <= order_q;
        fetch_seq_pkg::OFS_HOLD:  rdata_q[7:0]  <= hold_q;
        fetch_seq_pkg::OFS_WORD2: rdata_q       <= word2_q;
        fetch_seq_pkg::OFS_MADDR: rdata_q[16:0] <= maddr_q;
        default:                  rdata_q       <= '0;
      endcase
    end
  end

  // mode bits may change only while idle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      command_output_cycle_q <= 1'b0;
      out_type_q             <= 1'b0;
    end
    else if (avs_write & ack_q & (avs_address == fetch_seq_pkg::OFS_CTRL)
             & (phase_q == fetch_seq_pkg::PH_IDLE))
    begin
      command_output_cycle_q <= avs_writedata[fetch_seq_pkg::CTRL_ORDOUT];
      out_type_q             <= avs_writedata[fetch_seq_pkg::CTRL_OUTTYP];
    end
  end

  // phase sequence
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      phase_q <= fetch_seq_pkg::PH_IDLE;                        // R24
    else if (start)
      phase_q <= fetch_seq_pkg::PH_SETUP;
    else if (t4)
    begin
      unique case (phase_q)
        fetch_seq_pkg::PH_SETUP:  phase_q <= fetch_seq_pkg::PH_FETCH;      // R23
        fetch_seq_pkg::PH_FETCH:  phase_q <= fetch_seq_pkg::PH_ORDER;
        fetch_seq_pkg::PH_ORDER:
          phase_q <= go_on ? fetch_seq_pkg::PH_SECOND                      // R20
                           : fetch_seq_pkg::PH_FETCH;                      // R19 R22
        fetch_seq_pkg::PH_SECOND: phase_q <= fetch_seq_pkg::PH_IDLE;
        default:                  phase_q <= fetch_seq_pkg::PH_IDLE;
      endcase
    end
  end

  // timer launch waits on the phase's own start condition
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      wait_q <= 1'b0;                                           // R24
    else if (start | (t4 & (phase_q != fetch_seq_pkg::PH_SECOND)))
      wait_q <= 1'b1;
    else if (timer_go | (t4 & (phase_q == fetch_seq_pkg::PH_SECOND)))
      wait_q <= 1'b0;
  end

  always_comb
  begin
    timer_go = 1'b0;
    if (wait_q & ~timer_busy)
    begin
      unique case (phase_q)
        fetch_seq_pkg::PH_SETUP:  timer_go = 1'b1;
        fetch_seq_pkg::PH_FETCH:
          timer_go = ~memory_cycle_started_q | memory_reply_seen_q;        // R3
        fetch_seq_pkg::PH_ORDER:  timer_go = memory_reply_seen_q;          // R8
        fetch_seq_pkg::PH_SECOND: timer_go = memory_reply_seen_q;          // R21
        default:                  timer_go = 1'b0;
      endcase
    end
  end

  // command address: software loads it idle; jump target taken late in order-send
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      command_address_register_q <= fetch_seq_pkg::CADDR_RST;
    else if (avs_write & ack_q & (avs_address == fetch_seq_pkg::OFS_CADDR)
             & (phase_q == fetch_seq_pkg::PH_IDLE))
      command_address_register_q <= avs_writedata[15:0];
    else if (in_fetch & t1)
      command_address_register_q <= adder_q;                    // R5
    else if (in_order & t3 & ~go_on)
      command_address_register_q <= adder_q;                    // R19
  end

  // adder input register, carry and subtract
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      adder_q <= '0;
    else if (t4 & ((phase_q == fetch_seq_pkg::PH_SETUP) | in_order))
      adder_q <= '0;                                            // R2
    else if (in_fetch & t0)
      adder_q <= command_address_register_q
               + {15'h0000, adder_carry_in_q & ~subtract_q};   // R4 R5
    else if (in_order & t0 & jump_command_detect)
      adder_q <= word1_q[15:0];                                 // R12
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      adder_carry_in_q <= 1'b1;
      subtract_q       <= 1'b0;
    end
    else
    begin
      if (in_fetch & t0)
        subtract_q <= 1'b0;                                     // R4
      if (start)
        adder_carry_in_q <= 1'b1;
      else if (in_order & t4 & jump_command_detect)
        adder_carry_in_q <= 1'b1;                               // R17
    end
  end

  // memory address S15..S31, S31 in bit 0
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      maddr_q <= '0;
    else if (in_fetch & t0)
      maddr_q <= {command_address_register_q, 1'b0};            // R6 R7
    else if (in_order & t0)
      maddr_q[0] <= 1'b1;                                       // R10
  end

  // holding register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      hold_q <= fetch_seq_pkg::HOLD_RST;
    else if ((phase_q == fetch_seq_pkg::PH_SETUP) & t2 & out_type_q)
      hold_q[7:5] <= 3'h0;                                      // R1
    else if (avs_write & ack_q & (avs_address == fetch_seq_pkg::OFS_HOLD)
             & (phase_q == fetch_seq_pkg::PH_IDLE))
      hold_q <= avs_writedata[7:0];
  end

  // memory handshake; the second word is read unless jumping without error halt
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      req_q <= 1'b0;
    else
      req_q <= t1 & (in_fetch | (in_order & go_on));
  end

  assign mem_req  = req_q;
  assign mem_addr = maddr_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      memory_cycle_started_q <= 1'b0;
      memory_reply_seen_q    <= 1'b0;
      address_accepted_q     <= 1'b0;
    end
    else
    begin
      if (start)
        memory_cycle_started_q <= 1'b0;
      else if (req_q)
        memory_cycle_started_q <= 1'b1;
      // reply and accept in the request cycle still count
      if (mem_reply)
        memory_reply_seen_q <= 1'b1;
      else if (req_q | start)
        memory_reply_seen_q <= 1'b0;
      if (mem_addr_ack)
        address_accepted_q <= 1'b1;
      else if (req_q | start)
        address_accepted_q <= 1'b0;
    end
  end

  // memory words told apart by S31; the first reply lands after fetch has ended
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      word1_q <= '0;
      word2_q <= '0;
    end
    else if (mem_reply & ~maddr_q[0])
      word1_q <= mem_rdata;
    else if (mem_reply)
      word2_q <= mem_rdata;                                     // R21
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      parity_err_q <= 1'b0;
    else if (start)
      parity_err_q <= 1'b0;
    else if (mem_reply & ~maddr_q[0] & mem_parity_err)
      parity_err_q <= 1'b1;
  end

  // order lines to the controller
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      order_q <= '0;
    else if (start)
      order_q <= '0;
    else if (in_order & t0 & command_output_cycle_q)
      order_q <= word1_q[fetch_seq_pkg::ORDER_MSB -: 8];        // R9
  end

  assign order_lines = order_q;

  // error recording, held until the next service cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      error_halt_flag_q     <= 1'b0;
      memory_timeout_flag_q <= 1'b0;
      ctrl_err_q            <= 1'b0;
    end
    else if (start)
    begin
      error_halt_flag_q     <= 1'b0;
      memory_timeout_flag_q <= 1'b0;
      ctrl_err_q            <= 1'b0;
    end
    else
    begin
      if (in_order & t0 & parity_err_q)
        error_halt_flag_q <= 1'b1;                              // R11
      if (in_order & t0 & jump_command_detect & second_pass_flag_q)
      begin
        error_halt_flag_q <= 1'b1;                              // R13
        ctrl_err_q        <= 1'b1;
      end
      if (in_order & t4 & memory_cycle_started_q & ~address_accepted_q & ~mem_addr_ack)
      begin
        error_halt_flag_q     <= 1'b1;                          // R18
        memory_timeout_flag_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      second_pass_flag_q <= 1'b0;
    else if (start)
      second_pass_flag_q <= 1'b0;
    else if (in_order & t4)
      second_pass_flag_q <= 1'b1;                               // R14
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      buffer_sel_zero_q <= fetch_seq_pkg::BSEL0_RST;
    else if (start)
      buffer_sel_zero_q <= fetch_seq_pkg::BSEL0_RST;
    else if (in_order & t0 & ~jump_command_detect)
      buffer_sel_zero_q <= 1'b0;                                // R15
  end

  assign buffer_sel_zero = buffer_sel_zero_q;

  // strobe acknowledge: stage two closes it once the controller drops its strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      strobe_ack_arm_q       <= 1'b0;
      strobe_ack_stage_two_q <= 1'b0;
    end
    else if (start)
    begin
      strobe_ack_arm_q       <= 1'b0;
      strobe_ack_stage_two_q <= 1'b0;
    end
    else
    begin
      if (in_order & t2 & command_output_cycle_q & go_on)
        strobe_ack_arm_q <= 1'b1;                               // R16
      if (strobe_ack & ~req_strobe)
        strobe_ack_stage_two_q <= 1'b1;
    end
  end

  assign strobe_ack = strobe_ack_arm_q & ~strobe_ack_stage_two_q;     // R16

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      done_q <= 1'b0;
    else if (start)
      done_q <= 1'b0;
    else if ((phase_q == fetch_seq_pkg::PH_SECOND) & t4)
      done_q <= 1'b1;
  end

endmodule : channel_command_fetch_seq
`default_nettype wire

/* test/fetch_seq_monitor.sv */
// assertion monitor for the command fetch sequencer, bound to its top
// assumes one memory access in flight and a synchronous low reset
`timescale 1ns/1ps
`default_nettype none
module fetch_seq_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        mem_req,
  input wire logic [16:0] mem_addr,
  input wire logic        mem_addr_ack,
  input wire logic        mem_reply,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_parity_err,
  input wire logic [7:0]  order_lines,
  input wire logic        strobe_ack,
  input wire logic        req_strobe,
  input wire logic        buffer_sel_zero
);
  logic [16:0] ra_q;
  logic [15:0] tg_q;
  logic [7:0]  ob_q;
  logic [3:0]  sr_q;
  logic [1:0]  jc_q;
  logic        pend_q;
  logic        outst_q;
  wire logic   start_w = avs_write && !avs_waitrequest
    && avs_address == fetch_seq_pkg::OFS_CTRL && avs_writedata[fetch_seq_pkg::CTRL_START];
  // only first-word replies carry the order byte
  wire logic   rep1 = mem_reply && !ra_q[0];

  function automatic logic jmp(input logic [7:0] b);
    return b[3] && b[2:0] == 3'h0;
  endfunction : jmp

  always_ff @(posedge clk)
  begin
    if (mem_req)
      ra_q <= mem_addr;
    if (rep1)
      ob_q <= mem_rdata[31:24];
    if (rep1)
      tg_q <= mem_rdata[15:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sr_q <= 4'hf;
      jc_q <= 2'h0;
      pend_q <= 1'b0;
      outst_q <= 1'b0;
    end
    else
    begin
      sr_q <= rep1 ? 4'h0 : sr_q + {3'h0, sr_q != 4'hf};
      jc_q <= start_w ? 2'h0 : jc_q + {1'b0, rep1 && jmp(mem_rdata[31:24])};
      pend_q <= rep1 || (pend_q && !mem_req);
      outst_q <= mem_req || (outst_q && !mem_reply);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_fetch;
    !mem_req [*6] ##[1:6] mem_req;
  endsequence
  property p_wait;
    $rose(avs_read || avs_write) |-> s_answer;
  endproperty
  property p_rst;
    disable iff (1'b0) !rst_b |=> !mem_req && !strobe_ack && buffer_sel_zero && order_lines == 8'h00;
  endproperty
  property p_fetch;
    start_w |-> s_fetch;
  endproperty
  property p_second;
    mem_req && pend_q && !jmp(ob_q) |-> mem_addr == {ra_q[16:1], 1'b1};
  endproperty
  property p_jump;
    mem_req && pend_q && jmp(ob_q) && jc_q == 2'h1 |-> mem_addr == {tg_q, 1'b0};
  endproperty
  property p_order;
    $changed(order_lines) && order_lines != 8'h00 |-> order_lines == ob_q && sr_q <= 4'h4;
  endproperty
  property p_bsel;
    $fell(buffer_sel_zero) |-> !jmp(ob_q) && sr_q <= 4'h4;
  endproperty
  property p_ack_rise;
    $rose(strobe_ack) |-> (!jmp(ob_q) || jc_q == 2'h2) && sr_q inside {[2:7]};
  endproperty
  property p_ack_end;
    strobe_ack && !req_strobe |=> !strobe_ack;
  endproperty
  property p_one;
    mem_req |-> !outst_q ##1 !mem_req;
  endproperty
  property p_next;
    rep1 |-> ##[2:14] mem_req;
  endproperty

  a_wait: assert property (p_wait)
    else $error("bus answer not after one wait state");
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  a_fetch: assert property (p_fetch)
    else $error("fetch request out of time after start");
  a_second: assert property (p_second)
    else $error("second word address wrong");
  a_jump: assert property (p_jump)
    else $error("jump target address wrong");
  a_order: assert property (p_order)
    else $error("order lines wrong");
  a_bsel: assert property (p_bsel)
    else $error("buffer select cleared on jump");
  a_ack_rise: assert property (p_ack_rise)
    else $error("acknowledge raised wrongly");
  a_ack_end: assert property (p_ack_end)
    else $error("acknowledge held after strobe drop");
  a_one: assert property (p_one)
    else $error("memory request while one in flight");
  a_next: assert property (p_next)
    else $error("no request after first word");
endmodule : fetch_seq_monitor

bind channel_command_fetch_seq fetch_seq_monitor i_fetch_seq_monitor (.*);
`default_nettype wire

/* test/mem_ctrl_model.sv */
// core memory and device controller model for the fetch sequencer
// assumes the bench loads words and sets the delays while idle
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        mem_req,
  input wire logic [16:0] mem_addr,
  input wire logic        strobe_ack,
  input wire logic [3:0]  ack_dly,
  input wire logic [3:0]  rep_dly,
  input wire logic        perr_en,
  output logic            mem_addr_ack,
  output logic            mem_reply,
  output logic     [31:0] mem_rdata,
  output logic            mem_parity_err,
  output logic            req_strobe
);
  logic [31:0] words [64];
  logic [16:0] a_q;
  logic [3:0]  n_q;
  logic        busy_q;
  wire logic   due = busy_q && n_q == rep_dly;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      busy_q <= 1'b0;
    else if (mem_req)
      busy_q <= 1'b1;
    else if (due)
      busy_q <= 1'b0;
    n_q <= mem_req ? 4'h0 : n_q + 4'h1;
    if (mem_req)
      a_q <= mem_addr;
  end

  // a late accept lets the sequencer see a timeout
  assign mem_addr_ack = busy_q && n_q == ack_dly;

  // data line shows a changing pattern outside a reply
  always_ff @(posedge clk)
  begin
    mem_reply <= rst_b && due;
    mem_rdata <= !rst_b ? 32'h0 : due ? words[a_q[5:0]] : ~mem_rdata;
    mem_parity_err <= due && perr_en && !a_q[0];
  end

  // keep requesting until acknowledged, then drop
  always_ff @(posedge clk)
    req_strobe <= !rst_b || !strobe_ack;
endmodule : mem_ctrl_model
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the command fetch sequencer
// assumes the memory and controller model and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [15:0] ca;
    logic [7:0]  hold;
    logic        ot;
    logic [31:0] w1;
    logic [31:0] w2;
  } row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, mem_rdata, rd;
  logic        avs_waitrequest, mem_req, mem_addr_ack, mem_reply, mem_parity_err;
  logic [16:0] mem_addr;
  logic [7:0]  order_lines;
  logic        strobe_ack, req_strobe, buffer_sel_zero;
  logic        perr_en = 1'b0;
  logic        ot_sel = 1'b0;
  logic [3:0]  ack_dly = 4'h1;
  logic [3:0]  rep_dly = 4'h3;
  int          errors = 0;
  int          comparisons = 0;
  int          acks = 0;
  int          reqs = 0;
  logic [5:0]  ra [6] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h1c};
  row_t        rows [4] = '{
    '{16'h0001, 8'hff, 1'b1, 32'h0c00_0011, 32'h1234_5678},
    '{16'h0003, 8'he5, 1'b0, 32'h0900_0000, 32'h8000_0001},
    '{16'hffff, 8'ha0, 1'b1, 32'hf700_ffff, 32'h0000_0000},
    '{16'h0010, 8'h7c, 1'b0, 32'h0400_0002, 32'hffff_ffff}};

  always #5 clk = ~clk;
  channel_command_fetch_seq i_channel_command_fetch_seq (.*);
  mem_ctrl_model i_mem_ctrl_model (.*);

  always @(posedge clk)
  begin
    acks <= acks + int'(strobe_ack && !req_strobe);
    reqs <= reqs + int'(mem_req);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic run(input logic [15:0] ca, input logic [2:0] ctl);
    int n;
    bus(1'b1, fetch_seq_pkg::OFS_CADDR, {16'h0, ca});
    bus(1'b1, fetch_seq_pkg::OFS_CTRL, {29'h0, ctl});
    n = 0;
    do
    begin
      bus(1'b0, fetch_seq_pkg::OFS_STATUS, 32'h0);
      n++;
    end
    while (rd[fetch_seq_pkg::ST_DONE] !== 1'b1 && n < 100);
  endtask : run

  // status compared without carry-in and buffer select bits
  task automatic hand(input logic [15:0] ca, input logic [31:0] st, input logic [7:0] command_output_cycle,
                      input int nreq);
    int r0;
    r0 = reqs;
    run(ca, {ot_sel, 2'b11});
    chk(rd & ~32'h0a00, st);
    chk({24'h0, order_lines}, {24'h0, command_output_cycle});
    chk(32'(reqs - r0), 32'(nreq));
  endtask : hand

  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    #100000;
    errors++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, i == 0 ? 32'h0a00 : 32'h0);
    end
    foreach (rows[i])
    begin
      i_mem_ctrl_model.words[{rows[i].ca[4:0], 1'b0}] = rows[i].w1;
      i_mem_ctrl_model.words[{rows[i].ca[4:0], 1'b1}] = rows[i].w2;
      bus(1'b1, fetch_seq_pkg::OFS_HOLD, {24'h0, rows[i].hold});
      ot_sel = rows[i].ot;
      hand(rows[i].ca, 32'h0500, rows[i].w1[31:24], 2);
      chk({31'h0, buffer_sel_zero}, 32'h0);
      bus(1'b0, fetch_seq_pkg::OFS_HOLD, 32'h0);
      chk(rd, {24'h0, rows[i].hold & (rows[i].ot ? 8'h1f : 8'hff)});
      bus(1'b0, fetch_seq_pkg::OFS_CADDR, 32'h0);
      chk(rd, {16'h0, rows[i].ca + 16'h1});
      bus(1'b0, fetch_seq_pkg::OFS_MADDR, 32'h0);
      chk(rd, {15'h0, rows[i].ca, 1'b1});
      bus(1'b0, fetch_seq_pkg::OFS_WORD2, 32'h0);
      chk(rd, rows[i].w2);
    end
    chk(32'(acks), 32'h4);
    i_mem_ctrl_model.words[4] = 32'h0800_0005;
    i_mem_ctrl_model.words[10] = 32'h0300_0000;
    i_mem_ctrl_model.words[11] = 32'hcafe_0001;
    hand(16'h0002, 32'h0500, 8'h03, 3);
    bus(1'b0, fetch_seq_pkg::OFS_CADDR, 32'h0);
    chk(rd, 32'h0006);
    bus(1'b0, fetch_seq_pkg::OFS_WORD2, 32'h0);
    chk(rd, 32'hcafe_0001);
    i_mem_ctrl_model.words[16] = 32'h0800_000a;
    i_mem_ctrl_model.words[20] = 32'h1800_000c;
    i_mem_ctrl_model.words[21] = 32'h5555_aaaa;
    hand(16'h0008, 32'h0550, 8'h18, 3);
    chk(32'(acks), 32'h6);
    @(posedge clk);
    perr_en <= 1'b1;
    hand(16'h0001, 32'h0590, 8'h0c, 2);
    @(posedge clk);
    perr_en <= 1'b0;
    ack_dly <= 4'h8;
    rep_dly <= 4'ha;
    hand(16'h0003, 32'h0530, 8'h09, 2);
    close_out();
  end
endmodule : testbench
`default_nettype wire
